/* File: rtl/fesq_pkg.sv */
// Function
// - Chip erase: six writes AA/555, 55/2AA, 80/555, AA/555, 55/2AA, 10/555.
// - After chip erase, poll reads until the device returns FF.
// - Protect drives A6 low, A1 high; unprotect A6 high, A1 high, A0 low.
// - Protect: sector address, count 1, elevated OE and A9, CE low, A6 low, pulse.
// - After each protect pulse wait 150 us, then WE high, CE and OE low.
// - Verify at sector address with A0 and A1 high; 01 means protected.
// - On failed verify bump count and pulse again; fail at 32.
// - When done, drop elevated A9 voltage, then write the reset command.
package fesq_pkg;
    localparam int ADDR_W = 19;
    localparam int CLK_MHZ = 25;
    localparam logic [ADDR_W-1:0] ADDR_555 = 19'h00555;
    localparam logic [ADDR_W-1:0] ADDR_2AA = 19'h002AA;
    localparam logic [7:0] CMD_AA = 8'hAA;
    localparam logic [7:0] CMD_55 = 8'h55;
    localparam logic [7:0] CMD_80 = 8'h80;
    localparam logic [7:0] CMD_10 = 8'h10;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] ERASE_DONE = 8'hFF;
    localparam logic [7:0] PROT_CODE = 8'h01;
    localparam logic [5:0] MAX_PULSES = 6'h20;
    localparam int PULSE_WAIT_US = 150;
    localparam int PULSE_WAIT_CYC = PULSE_WAIT_US * CLK_MHZ;
    // Strobe phase lengths in cycles, less one; 40 ns each covers 35 ns pulses
    localparam logic [3:0] STROBE_CYC = 4'h2;
    localparam logic [3:0] SETUP_CYC = 4'h1;
    localparam int BIT_A0 = 0;
    localparam int BIT_A1 = 1;
    localparam int BIT_A6 = 6;
    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic oe_hv;
        logic a9_hv;
        logic [ADDR_W-1:0] addr;
    } fesq_pins_t;
    typedef enum logic [1:0] {OP_ERASE, OP_PROTECT, OP_UNPROTECT}
        fesq_op_t;
endpackage

/* File: rtl/fesq_host.sv */
`timescale 1ns/1ns
module fesq_host
    import fesq_pkg::*;
#(
    parameter int PULSE_WAIT = PULSE_WAIT_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire fesq_op_t i_op,
    input wire logic [ADDR_W-1:0] i_sector_addr,
    output logic o_busy,
    output logic o_done,
    output logic o_fail,
    output fesq_pins_t o_pins,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    input wire logic [7:0] i_dq
);
    typedef enum {
        ST_IDLE, ST_CMD_SET, ST_CMD_WE, ST_CMD_GAP, ST_POLL_OE,
        ST_POLL_CHK, ST_HV_SET, ST_HV_WE, ST_HV_WAIT, ST_VFY_OE,
        ST_VFY_CHK, ST_HV_OFF, ST_RST_SET, ST_RST_WE, ST_END
    } fesq_st_t;

    fesq_st_t st_r, st_nxt;
    logic [2:0] step_r;
    logic [5:0] pulse_cnt_r;
    logic [31:0] tmr_r;
    logic [ADDR_W-1:0] sect_r;
    fesq_op_t op_r;
    logic fail_r, done_r;
    logic [7:0] dq_r;

    function automatic logic [ADDR_W+7:0] erase_step(input logic [2:0] s);
        case (s)
            3'h0: erase_step = {ADDR_555, CMD_AA};
            3'h1: erase_step = {ADDR_2AA, CMD_55};
            3'h2: erase_step = {ADDR_555, CMD_80};
            3'h3: erase_step = {ADDR_555, CMD_AA};
            3'h4: erase_step = {ADDR_2AA, CMD_55};
            default: erase_step = {ADDR_555, CMD_10};
        endcase
    endfunction

    wire [ADDR_W+7:0] cur_cmd = erase_step(step_r);
    wire tmr_done = (tmr_r == 32'h0);
    wire erase_ok = (dq_r == ERASE_DONE);
    wire prot_ok = (dq_r == PROT_CODE);
    wire unprot = (op_r == OP_UNPROTECT);
    wire hv_phase = (st_r == ST_HV_SET) || (st_r == ST_HV_WE) ||
        (st_r == ST_HV_WAIT) || (st_r == ST_VFY_OE) || (st_r == ST_VFY_CHK);
    // OE leaves the elevated level before the verify read; only A9 stays up
    wire hv_pulse = (st_r == ST_HV_SET) || (st_r == ST_HV_WE) ||
        (st_r == ST_HV_WAIT);
    // Sector address with the mode bits forced
    wire [ADDR_W-1:0] hv_addr_pulse = unprot ?
        ((sect_r | (19'h1 << BIT_A6) | (19'h1 << BIT_A1)) & ~19'h1) :
        ((sect_r & ~(19'h1 << BIT_A6)) | (19'h1 << BIT_A1));
    wire [ADDR_W-1:0] hv_addr_vfy = sect_r | (19'h1 << BIT_A0) |
        (19'h1 << BIT_A1);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
                if (i_start)
                    st_nxt = (i_op == OP_ERASE) ? ST_CMD_SET : ST_HV_SET;
            ST_CMD_SET:
                if (tmr_done)
                    st_nxt = ST_CMD_WE;
            ST_CMD_WE:
                if (tmr_done)
                    st_nxt = ST_CMD_GAP;
            ST_CMD_GAP:
                if (tmr_done)
                    st_nxt = (step_r == 3'h5) ? ST_POLL_OE : ST_CMD_SET;
            ST_POLL_OE:
                if (tmr_done)
                    st_nxt = ST_POLL_CHK;
            ST_POLL_CHK:
                st_nxt = erase_ok ? ST_END : ST_POLL_OE;
            ST_HV_SET:
                if (tmr_done)
                    st_nxt = ST_HV_WE;
            ST_HV_WE:
                if (tmr_done)
                    st_nxt = ST_HV_WAIT;
            ST_HV_WAIT:
                if (tmr_done)
                    st_nxt = ST_VFY_OE;
            ST_VFY_OE:
                if (tmr_done)
                    st_nxt = ST_VFY_CHK;
            ST_VFY_CHK:
                if (prot_ok || unprot)
                    st_nxt = ST_HV_OFF;
                else if (pulse_cnt_r == MAX_PULSES)
                    st_nxt = ST_HV_OFF;
                else
                    st_nxt = ST_HV_SET;
            ST_HV_OFF:
                if (tmr_done)
                    st_nxt = ST_RST_SET;
            ST_RST_SET:
                if (tmr_done)
                    st_nxt = ST_RST_WE;
            ST_RST_WE:
                if (tmr_done)
                    st_nxt = ST_END;
            ST_END:
                st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    wire entering = (st_nxt != st_r);
    wire [31:0] tmr_load = (st_nxt == ST_HV_WAIT) ? 32'(PULSE_WAIT - 1) :
        (st_nxt == ST_CMD_SET || st_nxt == ST_RST_SET ||
         st_nxt == ST_HV_OFF) ? 32'(SETUP_CYC) : 32'(STROBE_CYC);

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            st_r <= ST_IDLE;
            tmr_r <= 32'h0;
        end
        else
        begin
            st_r <= st_nxt;
            tmr_r <= entering ? tmr_load : (tmr_done ? tmr_r : tmr_r - 1);
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            step_r <= 3'h0;
            pulse_cnt_r <= 6'h0;
            sect_r <= '0;
            op_r <= OP_ERASE;
            fail_r <= 1'b0;
            done_r <= 1'b0;
            dq_r <= 8'h0;
        end
        else
        begin
            done_r <= (st_r == ST_END);
            if (st_r == ST_IDLE && i_start)
            begin
                op_r <= i_op;
                sect_r <= i_sector_addr;
                step_r <= 3'h0;
                pulse_cnt_r <= 6'h1;
                fail_r <= 1'b0;
            end
            if (st_r == ST_CMD_GAP && tmr_done)
                step_r <= step_r + 3'h1;
            if ((st_r == ST_POLL_OE || st_r == ST_VFY_OE) && tmr_done)
                dq_r <= i_dq;
            if (st_r == ST_VFY_CHK && !(prot_ok || unprot))
            begin
                if (pulse_cnt_r == MAX_PULSES)
                    fail_r <= 1'b1;
                else
                    pulse_cnt_r <= pulse_cnt_r + 6'h1;
            end
        end
    end

    always_comb
    begin
        o_pins.ce_n = 1'b1;
        o_pins.we_n = 1'b1;
        o_pins.oe_n = 1'b1;
        o_pins.oe_hv = hv_pulse;
        o_pins.a9_hv = hv_phase;
        o_pins.addr = sect_r;
        o_dq = dq_r;
        o_dq_oe = 1'b0;
        case (st_r)
            ST_CMD_SET, ST_CMD_WE:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.we_n = (st_r != ST_CMD_WE);
                o_pins.addr = cur_cmd[ADDR_W+7:8];
                o_dq = cur_cmd[7:0];
                o_dq_oe = 1'b1;
            end
            ST_POLL_OE:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.oe_n = 1'b0;
            end
            ST_HV_SET, ST_HV_WE:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.we_n = (st_r != ST_HV_WE);
                o_pins.addr = hv_addr_pulse;
            end
            ST_HV_WAIT:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.addr = hv_addr_pulse;
            end
            ST_VFY_OE, ST_VFY_CHK:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.oe_n = 1'b0;
                o_pins.addr = hv_addr_vfy;
            end
            ST_RST_SET, ST_RST_WE:
            begin
                o_pins.ce_n = 1'b0;
                o_pins.we_n = (st_r != ST_RST_WE);
                o_dq = CMD_RESET;
                o_dq_oe = 1'b1;
            end
            default:
            begin
            end
        endcase
    end

    // oe_hv means OE at elevated voltage; the board mux gives it priority
    assign o_busy = (st_r != ST_IDLE);
    assign o_done = done_r;
    assign o_fail = fail_r;
endmodule

/* File: testbench/fesq_flash_model.sv */
`timescale 1ns/1ns
module fesq_flash_model
    import fesq_pkg::*;
#(parameter int POLLS = 5)
(
    input wire logic i_clk,
    input wire fesq_pins_t i_pins,
    input wire logic [7:0] i_dq,
    input wire logic i_prot_ok,
    output logic [7:0] o_dq
);
    // Strobe edges are taken on the clock: decoded host pins may glitch
    // in zero time, and CE rises in the same step as WE or OE
    // Negative seq counts the status reads left before erase completes
    int seq = 0;
    logic prot = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] rd_val = 8'h00;
    logic [7:0] pd = 8'h00;
    fesq_pins_t pp = '1;
    wire rd = i_pins.ce_n === 1'b0 && i_pins.oe_n === 1'b0 &&
        i_pins.oe_hv === 1'b0;
    wire vfy = i_pins.a9_hv && i_pins.addr[1:0] == 2'b11;
    wire [7:0] val = seq < 0 ? {~ERASE_DONE[7], 7'h00} :
        vfy ? {7'h00, prot} : ERASE_DONE;
    // Released bus shows the inverse of the last value, never a held copy
    assign o_dq = rd ? val : ~last;
    always @(posedge i_clk)
    begin
        pp <= i_pins;
        pd <= i_dq;
        if (rd)
            rd_val <= val;
        if (!pp.ce_n && !pp.oe_n && !pp.oe_hv && i_pins.oe_n)
        begin
            last <= rd_val;
            if (seq < 0)
                seq <= seq + 1;
        end
        if (!pp.ce_n && !pp.we_n && i_pins.we_n)
        begin
            if (pp.a9_hv)
                prot <= !pp.addr[BIT_A6] && i_prot_ok;
            else
                seq <= pd == CMD_10 && seq == 5 ? -POLLS :
                    pd == CMD_RESET || seq == 5 ? 0 : seq + 1;
        end
    end
endmodule

/* File: testbench/fesq_host_chk.sv */
`timescale 1ns/1ns
module fesq_host_chk
    import fesq_pkg::*;
#(parameter int PULSE_WAIT = 4)
(
    input wire logic i_core_clk, i_rstn, i_start,
    input wire fesq_op_t i_op,
    input wire logic [ADDR_W-1:0] i_sector_addr,
    input wire logic o_busy, o_done, o_fail, o_dq_oe,
    input wire fesq_pins_t o_pins,
    input wire logic [7:0] o_dq, i_dq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    wire wr = !o_pins.we_n && !o_pins.ce_n, hv = o_pins.a9_hv;
    a_reset_idle: assert property (disable iff (1'b0) !i_rstn |=>
        !o_busy && o_pins.we_n && !hv && !o_dq_oe) else $error("not idle");
    a_hv_a1: assert property (wr && hv |-> o_pins.addr[BIT_A1])
        else $error("A1 low at pulse");
    a_hv_pulse: assert property (wr && hv |-> o_pins.oe_hv)
        else $error("OE not elevated");
    a_cmd_drive: assert property (wr && !hv |-> o_dq_oe && o_pins.oe_n)
        else $error("write not driven");
    a_cmd_2aa: assert property (wr && !hv && o_pins.addr == ADDR_2AA
        |-> o_dq == CMD_55) else $error("bad data at 2AA");
    a_hv_hold: assert property ($rose(o_pins.we_n) && hv && PULSE_WAIT > 3
        |-> hv[*4]) else $error("A9 dropped in wait");
    a_hv_reset: assert property ($fell(hv) |->
        ##[1:8] wr && o_dq == CMD_RESET) else $error("no reset write");
    a_fail_done: assert property ($rose(o_fail) |-> ##[1:40] o_done)
        else $error("no done after fail");
    a_vfy_oe_low: assert property (!o_pins.oe_n && hv |-> !o_pins.oe_hv)
        else $error("OE elevated in verify read");
    a_unprot_a0: assert property (wr && hv && o_pins.addr[BIT_A6]
        |-> !o_pins.addr[BIT_A0]) else $error("A0 high at unprotect");
    c_unprot: cover property (wr && hv && o_pins.addr[BIT_A6]);
    c_erase: cover property (wr && o_dq == CMD_10);
    c_prot: cover property (wr && hv);
    c_fail: cover property ($rose(o_fail));
endmodule
bind fesq_host fesq_host_chk #(.PULSE_WAIT(PULSE_WAIT)) u_chk (.*);

/* File: testbench/fesq_host_bench.sv */
`timescale 1ns/1ns
module fesq_host_bench;
    import fesq_pkg::*;
    localparam int POLLS = 5;
    localparam logic [26:0] EXP_W [6] = '{{ADDR_555, CMD_AA},
        {ADDR_2AA, CMD_55}, {ADDR_555, CMD_80}, {ADDR_555, CMD_AA},
        {ADDR_2AA, CMD_55}, {ADDR_555, CMD_10}};
    logic i_core_clk = 1'b0, i_rstn = 1'b0, i_start = 1'b0, prot_ok = 1'b1;
    fesq_op_t i_op = OP_ERASE;
    logic [ADDR_W-1:0] i_sector_addr = '0;
    logic o_busy, o_done, o_fail, o_dq_oe;
    fesq_pins_t o_pins;
    logic [7:0] o_dq, mdl_dq;
    wire [7:0] i_dq = o_dq_oe ? o_dq : mdl_dq;
    logic [31:0] seed = 32'h61AD1A73;
    int error_cnt = 0, total_checks = 0, n_rd, n_hv;
    logic [26:0] wq[$];
    always #20 i_core_clk = ~i_core_clk;
    fesq_host #(.PULSE_WAIT(4)) i_fesq_host (.*);
    fesq_flash_model #(.POLLS(POLLS)) i_fesq_flash_model (.i_clk(i_core_clk),
        .i_pins(o_pins), .i_dq(i_dq), .i_prot_ok(prot_ok), .o_dq(mdl_dq));
    // Bus cycles are counted on the clock; the pins may glitch in zero time
    fesq_pins_t pp = '1;
    logic [7:0] pd = 8'h00;
    always @(posedge i_core_clk)
    begin
        pp <= o_pins;
        pd <= i_dq;
        if (!pp.ce_n && !pp.we_n && o_pins.we_n)
        begin
            if (pp.a9_hv)
                n_hv++;
            else
                wq.push_back({pp.addr, pd});
        end
        if (!pp.ce_n && !pp.oe_n && o_pins.oe_n)
            n_rd++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) error_cnt++;
        if (got !== exp)
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic run(input fesq_op_t op, input logic ok);
        seed = xs(seed);
        @(posedge i_core_clk);
        #1 i_op = op;
        i_start = 1'b1;
        prot_ok = ok;
        i_sector_addr = seed[ADDR_W-1:0];
        {n_rd, n_hv} = '0;
        wq.delete();
        @(posedge i_core_clk);
        #1 i_start = 1'b0;
        for (int n = 0; n < 9000 && o_done !== 1'b1; n++)
            @(negedge i_core_clk);
        check(o_done, 1'b1);
        check(o_busy, 1'b0);
    endtask
    task automatic print_verdict(input int extra);
        error_cnt += extra;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Four runs take well under 40k cycles; the limit leaves margin
    initial #2000000 print_verdict(1);
    initial
    begin
        repeat (10) @(posedge i_core_clk);
        #1 i_rstn = 1'b1;
        run(OP_ERASE, 1'b1);
        check(wq.size(), 6);
        foreach (EXP_W[i]) check(wq[i], EXP_W[i]);
        check(n_rd, POLLS + 1);
        run(OP_PROTECT, 1'b1);
        check({o_fail, n_hv[7:0]}, 9'h001);
        run(OP_PROTECT, 1'b0);
        check({o_fail, n_hv[7:0]}, 9'h120);
        run(OP_UNPROTECT, 1'b1);
        check({o_fail, n_hv[7:0]}, 9'h001);
        print_verdict(0);
    end
endmodule
